/* File: logic/flash_host_defines.svh */
/*
 * Constants for the parallel flash command host: pin timing, command
 * bytes, command addresses and derived cycle counts.
 * Assumes a 40 MHz mclk; cycle counts derive from the clock period and frequency below, the read strobe adding SYNC_STAGES.
 */
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// ****************************************************
// Clock and pin timing
// ****************************************************
`define CLK_PERIOD_NS   25
`define CLK_HZ          40000000
`define T_WP_NS         100
`define T_WPH_NS        50
`define T_ACC_NS        55
`define T_OEHP_NS       150
`define T_EC_S          10
`define SYNC_STAGES     2
`define ERASE_TMO_CYC   (`T_EC_S * `CLK_HZ)

// ****************************************************
// Pin widths and command encoding
// ****************************************************
`define ADDR_W          19
`define DATA_W          16
`define CMD_ADDR_1      16'h5555
`define CMD_ADDR_2      16'h2AAA
`define CMD_UNLOCK_1    8'hAA
`define CMD_UNLOCK_2    8'h55
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE  8'h10
`define CMD_SECT_ERASE  8'h30
`define CMD_ID_ENTER    8'h90
`define CMD_ID_EXIT     8'hF0
`define TOGGLE_BIT_POS  6
`define ERASE_SEQ_LEN   3'h6
`define ID_SEQ_LEN      3'h3

`endif

/* File: logic/flash_host_pkg.sv */
/*
 * Types shared by the flash command host and its pin cycle engine.
 * Assumes flash_host_defines.svh is on the include path.
 */
`include "flash_host_defines.svh"

package flash_host_pkg;

  // ****************************************************
  // Host operations
  // ****************************************************
  typedef enum logic [2:0] {
    OP_CHIP_ERASE,
    OP_SECT_ERASE,
    OP_ID_ENTER,
    OP_ID_EXIT,
    OP_ID_EXIT_SHORT,
    OP_READ
  } op_t;

  // ****************************************************
  // One pin cycle and the pin bundle
  // ****************************************************
  typedef struct packed {
    logic               wr;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } bus_req_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] dq_out;
    logic               dq_oe;
    logic               ce_n;
    logic               oe_n;
    logic               we_n;
    logic               reset_n;
  } flash_pins_t;

  // Least time in ns to whole clock cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

/* File: logic/flash_pin_cycle.sv */
/*
 * Pin cycle engine: runs one write or read cycle on the flash pins.
 * Assumes one request at a time, offered only while req_ready is high.
 */
module flash_pin_cycle
  import flash_host_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // Request and answer
  input  wire logic                 req_valid,
  input  wire bus_req_t             req,
  output logic                      req_ready,
  output logic                      done,
  output logic [`DATA_W-1:0]        rd_data,
  // Flash pins
  output flash_pins_t               pins,
  input  wire logic [`DATA_W-1:0]   dq_in
);

  // ****************************************************
  // Cycle counts
  // ****************************************************
  localparam logic [3:0] WR_LOW  = 4'(ns_to_cyc(`T_WP_NS));
  localparam logic [3:0] WR_HIGH = 4'(ns_to_cyc(`T_WPH_NS));
  // Read strobe covers access time plus the input synchroniser
  localparam logic [3:0] RD_LOW  = 4'(ns_to_cyc(`T_ACC_NS) + `SYNC_STAGES);
  localparam logic [3:0] RD_HIGH = 4'(ns_to_cyc(`T_OEHP_NS));

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_RECOVER} cyc_st_t;

  cyc_st_t              st_ff,   nxt_st;
  logic [3:0]           cnt_ff,  nxt_cnt;
  flash_pins_t          pins_ff, nxt_pins;
  logic [`DATA_W-1:0]   rd_ff,   nxt_rd;
  logic                 done_ff, nxt_done;
  logic [`DATA_W-1:0]   dq_s1_ff;
  logic [`DATA_W-1:0]   dq_s2_ff;

  // ****************************************************
  // Next cycle
  // ****************************************************
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_pins = pins_ff;
    nxt_rd   = rd_ff;
    nxt_done = 1'b0;
    nxt_pins.reset_n = 1'b1;
    unique case (st_ff)
      CY_IDLE: begin
        if (req_valid) begin
          nxt_pins.addr   = req.addr;
          nxt_pins.dq_out = req.data;
          nxt_pins.dq_oe  = req.wr;
          nxt_st          = CY_SETUP;
        end
      end
      CY_SETUP: begin
        // Writes keep OE high under WE and CE low; reads pulse CE and OE
        nxt_pins.ce_n = 1'b0;
        nxt_pins.we_n = ~pins_ff.dq_oe;
        nxt_pins.oe_n = pins_ff.dq_oe;
        nxt_cnt       = pins_ff.dq_oe ? WR_LOW : RD_LOW;
        nxt_st        = CY_STROBE;
      end
      CY_STROBE: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          if (!pins_ff.dq_oe) begin
            nxt_rd = dq_s2_ff;
          end
          nxt_pins.ce_n = 1'b1;
          nxt_pins.we_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_cnt       = pins_ff.dq_oe ? WR_HIGH : RD_HIGH;
          nxt_st        = CY_RECOVER;
        end
      end
      CY_RECOVER: begin
        // Data stays driven through recovery to cover hold time
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          nxt_pins.dq_oe = 1'b0;
          nxt_done       = 1'b1;
          nxt_st         = CY_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff    <= CY_IDLE;
      cnt_ff   <= 4'h0;
      pins_ff  <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1,
                    oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0};
      rd_ff    <= '0;
      done_ff  <= 1'b0;
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end else if (clk_en) begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      pins_ff  <= nxt_pins;
      rd_ff    <= nxt_rd;
      done_ff  <= nxt_done;
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  assign req_ready = (st_ff == CY_IDLE);
  assign done      = done_ff;
  assign rd_data   = rd_ff;
  assign pins      = pins_ff;

endmodule // flash_pin_cycle

/* File: logic/flash_cmd_host.sv */
/*
 * Flash command host: turns single host operations into flash command
 * sequences on the pins, and polls the toggle status bit after erase.
 * Assumes one flash device on the pins and a caller that waits for
 * cmd_ready before offering the next operation.
 */
// Notes on behaviour
// - Chip erase ends with byte 10 written at address 5555.
// - Sector erase ends with byte 30 written to an address inside the sector.
// - Command writes hold output enable high while write strobe and select are low.
// - Each output-enable or select pulse during busy time is one status read.
// - Status polling keeps one fixed address across all reads.
// - Completion is judged by the status bit staying the same across two reads, never by its level.
// - Command bytes use data lines seven to zero; upper lines are ignored.
// - Command addresses sit on low sixteen lines, upper lines driven defined.
module flash_cmd_host
  import flash_host_pkg::*;
#(
  parameter int unsigned ERASE_TMO = `ERASE_TMO_CYC
)
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // Operation request
  input  wire logic                 cmd_valid,
  input  wire op_t                  cmd_op,
  input  wire logic [`ADDR_W-1:0]   cmd_addr,
  output logic                      cmd_ready,
  // Operation answer
  output logic                      rsp_valid,
  output logic [`DATA_W-1:0]        rsp_data,
  output logic                      rsp_timeout,
  // Flash pins
  output flash_pins_t               pins,
  input  wire logic [`DATA_W-1:0]   dq_in
);

  // ****************************************************
  // Command step lookup
  // ****************************************************
  // Command writes: byte on the low lane, upper lanes and upper address lines zero
  function automatic bus_req_t cmd_wr(input logic [15:0] a, input logic [7:0] d);
    bus_req_t r;
    r.wr   = 1'b1;
    r.addr = {3'h0, a};
    r.data = {8'h00, d};
    return r;
  endfunction

  function automatic logic [2:0] seq_len(input op_t op);
    unique case (op)
      OP_CHIP_ERASE, OP_SECT_ERASE: return `ERASE_SEQ_LEN;
      OP_ID_ENTER, OP_ID_EXIT:      return `ID_SEQ_LEN;
      OP_ID_EXIT_SHORT, OP_READ:    return 3'h1;
      default:                      return 3'h1;
    endcase
  endfunction

  function automatic bus_req_t seq_step(input op_t op, input logic [2:0] idx,
                                        input logic [`ADDR_W-1:0] a);
    bus_req_t r;
    r = cmd_wr(`CMD_ADDR_1, `CMD_UNLOCK_1);
    if (op == OP_READ) begin
      // Identification reads pass the caller's address bit zero through
      r = '{wr: 1'b0, addr: a, data: '0};
    end else if (op == OP_ID_EXIT_SHORT) begin
      r = cmd_wr(`CMD_ADDR_1, `CMD_ID_EXIT);
    end else begin
      unique case (idx)
        3'h0, 3'h3: r = cmd_wr(`CMD_ADDR_1, `CMD_UNLOCK_1);
        3'h1, 3'h4: r = cmd_wr(`CMD_ADDR_2, `CMD_UNLOCK_2);
        3'h2: begin
          if (op == OP_ID_ENTER) begin
            r = cmd_wr(`CMD_ADDR_1, `CMD_ID_ENTER);
          end else if (op == OP_ID_EXIT) begin
            r = cmd_wr(`CMD_ADDR_1, `CMD_ID_EXIT);
          end else begin
            r = cmd_wr(`CMD_ADDR_1, `CMD_ERASE_SETUP);
          end
        end
        3'h5: begin
          if (op == OP_SECT_ERASE) begin
            r      = cmd_wr(16'h0000, `CMD_SECT_ERASE);
            r.addr = a;
          end else begin
            r = cmd_wr(`CMD_ADDR_1, `CMD_CHIP_ERASE);
          end
        end
        default: r = cmd_wr(`CMD_ADDR_1, `CMD_UNLOCK_1);
      endcase
    end
    return r;
  endfunction

  // ****************************************************
  // Sequencer state
  // ****************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_RESP} host_st_t;

  host_st_t             st_ff,      nxt_st;
  op_t                  op_ff,      nxt_op;
  logic [`ADDR_W-1:0]   addr_ff,    nxt_addr;
  logic [2:0]           idx_ff,     nxt_idx;
  logic                 poll_ff,    nxt_poll;
  logic                 have_ff,    nxt_have;
  logic                 prev_ff,    nxt_prev;
  logic [31:0]          tmo_ff,     nxt_tmo;
  logic                 ready_ff,   nxt_ready;
  logic                 rsp_ff,     nxt_rsp;
  logic [`DATA_W-1:0]   data_ff,    nxt_data;
  logic                 tout_ff,    nxt_tout;
  logic                 bvalid_ff,  nxt_bvalid;
  bus_req_t             breq_ff,    nxt_breq;

  logic                 b_ready;
  logic                 b_done;
  logic [`DATA_W-1:0]   b_rd;
  logic                 tog;

  assign tog = b_rd[`TOGGLE_BIT_POS];

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    nxt_st     = st_ff;
    nxt_op     = op_ff;
    nxt_addr   = addr_ff;
    nxt_idx    = idx_ff;
    nxt_poll   = poll_ff;
    nxt_have   = have_ff;
    nxt_prev   = prev_ff;
    nxt_tmo    = poll_ff ? tmo_ff + 32'h1 : tmo_ff;
    nxt_ready  = ready_ff;
    nxt_rsp    = 1'b0;
    nxt_data   = data_ff;
    nxt_tout   = tout_ff;
    nxt_bvalid = 1'b0;
    nxt_breq   = breq_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (cmd_valid && ready_ff) begin
          nxt_op     = cmd_op;
          nxt_addr   = cmd_addr;
          nxt_idx    = 3'h0;
          nxt_ready  = 1'b0;
          nxt_tout   = 1'b0;
          nxt_bvalid = 1'b1;
          nxt_breq   = seq_step(cmd_op, 3'h0, cmd_addr);
          nxt_st     = ST_ISSUE;
        end else if (!cmd_valid) begin
          nxt_ready  = 1'b1;
        end
      end
      ST_ISSUE: begin
        // Engine is idle here, so the request is taken on this edge
        if (b_ready) begin
          nxt_st = ST_WAIT;
        end else begin
          nxt_bvalid = 1'b1;
        end
      end
      ST_WAIT: begin
        if (b_done) begin
          if (poll_ff) begin
            nxt_data = b_rd;
            // Only two equal reads in a row matter, never the level
            if (have_ff && (tog == prev_ff)) begin
              nxt_poll = 1'b0;
              nxt_st   = ST_RESP;
            end else if (tmo_ff >= ERASE_TMO) begin
              nxt_poll = 1'b0;
              nxt_tout = 1'b1;
              nxt_st   = ST_RESP;
            end else begin
              nxt_prev   = tog;
              nxt_have   = 1'b1;
              nxt_bvalid = 1'b1;
              // Same address for every status read
              nxt_breq   = '{wr: 1'b0, addr: addr_ff, data: '0};
              nxt_st     = ST_ISSUE;
            end
          end else if (op_ff == OP_READ) begin
            nxt_data = b_rd;
            nxt_st   = ST_RESP;
          end else if (idx_ff == seq_len(op_ff) - 3'h1) begin
            if (op_ff == OP_CHIP_ERASE || op_ff == OP_SECT_ERASE) begin
              // Busy flash ignores commands, so only status reads follow
              nxt_poll   = 1'b1;
              nxt_have   = 1'b0;
              nxt_tmo    = 32'h0;
              nxt_bvalid = 1'b1;
              nxt_breq   = '{wr: 1'b0, addr: addr_ff, data: '0};
              nxt_st     = ST_ISSUE;
            end else begin
              nxt_st = ST_RESP;
            end
          end else begin
            nxt_idx    = idx_ff + 3'h1;
            nxt_bvalid = 1'b1;
            nxt_breq   = seq_step(op_ff, idx_ff + 3'h1, addr_ff);
            nxt_st     = ST_ISSUE;
          end
        end
      end
      ST_RESP: begin
        nxt_rsp   = 1'b1;
        nxt_ready = 1'b1;
        nxt_st    = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff     <= ST_IDLE;
      op_ff     <= OP_READ;
      addr_ff   <= '0;
      idx_ff    <= 3'h0;
      poll_ff   <= 1'b0;
      have_ff   <= 1'b0;
      prev_ff   <= 1'b0;
      tmo_ff    <= 32'h0;
      ready_ff  <= 1'b0;
      rsp_ff    <= 1'b0;
      data_ff   <= '0;
      tout_ff   <= 1'b0;
      bvalid_ff <= 1'b0;
      breq_ff   <= '0;
    end else if (clk_en) begin
      st_ff     <= nxt_st;
      op_ff     <= nxt_op;
      addr_ff   <= nxt_addr;
      idx_ff    <= nxt_idx;
      poll_ff   <= nxt_poll;
      have_ff   <= nxt_have;
      prev_ff   <= nxt_prev;
      tmo_ff    <= nxt_tmo;
      ready_ff  <= nxt_ready;
      rsp_ff    <= nxt_rsp;
      data_ff   <= nxt_data;
      tout_ff   <= nxt_tout;
      bvalid_ff <= nxt_bvalid;
      breq_ff   <= nxt_breq;
    end
  end

  // ****************************************************
  // Pin cycle engine
  // ****************************************************
  flash_pin_cycle u_cycle (
    .mclk      (mclk),
    .rst       (rst),
    .clk_en    (clk_en),
    .req_valid (bvalid_ff),
    .req       (breq_ff),
    .req_ready (b_ready),
    .done      (b_done),
    .rd_data   (b_rd),
    .pins      (pins),
    .dq_in     (dq_in)
  );

  assign cmd_ready   = ready_ff;
  assign rsp_valid   = rsp_ff;
  assign rsp_data    = data_ff;
  assign rsp_timeout = tout_ff;

endmodule // flash_cmd_host

/* File: bench/flash_cmd_host_asserts.sv */
/* Checker for the flash command host: pin and command port properties.
   Assumes a bind to flash_cmd_host, one clock mclk and reset rst. */
`include "flash_host_defines.svh"
module flash_cmd_host_asserts
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        clk_en,
  // Command port
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  // Flash pins
  input wire flash_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Pin cycle properties
  // ********************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr;
  assign wr = !pins.ce_n && !pins.we_n;
  write_oe_high_a: assert property (wr |-> pins.oe_n)
    else $error("Output enable low in a write");
  cmd_byte_low_a: assert property (wr |-> pins.dq_oe && pins.dq_out[15:8] == 8'h00)
    else $error("Command write with upper data set");
  cmd_addr_upper_a: assert property (wr && pins.addr[15:0] == 16'h2AAA
    |-> pins.addr[18:16] == 3'h0) else $error("Unlock address upper lines set");
  write_width_a: assert property ($fell(pins.we_n) |-> !pins.we_n [*4] ##1 pins.we_n)
    else $error("Write strobe low time wrong");
  oe_high_pulse_a: assert property ($rose(pins.oe_n) |-> pins.oe_n [*6])
    else $error("Output enable high pulse too short");
  read_no_drive_a: assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n)
    else $error("Host drives data during a read");
  read_addr_hold_a: assert property (!pins.oe_n && !$fell(pins.oe_n) |-> $stable(pins.addr))
    else $error("Address moved during a read");
  // ********************
  // Command port and reset pin properties
  // ********************
  accept_drop_a: assert property (cmd_valid && cmd_ready && clk_en |=> !cmd_ready)
    else $error("Ready stayed high after accept");
  rsp_ready_a: assert property (rsp_valid |-> cmd_ready && !$past(cmd_ready))
    else $error("Ready not rising with answer");
  reset_pins_a: assert property (disable iff (1'b0) rst && $past(rst)
    |-> !pins.reset_n && pins.ce_n && pins.oe_n && pins.we_n && !pins.dq_oe)
    else $error("Pins not idle in reset");
endmodule // flash_cmd_host_asserts

/* File: bench/flash_dev_model.sv */
/* Behavioural flash device: command decoder, toggle status, ID mode.
   Assumes the host pins bundle; bench controls busy length and power. */
`include "flash_host_defines.svh"
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h00C3, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h005C  // Arbitrary value
)
(
  // Pins
  input  wire flash_pins_t  pins,
  output logic [15:0]       dq,
  // Bench control and status
  input  wire logic         pwr_off,
  input  wire logic [15:0]  busy_reads,
  output logic              id_mode = 1'b0,
  output logic [2:0]        erase_kind = 3'h0,
  output logic [18:0]       erase_addr = '0,
  output int                n_reads = 0,
  output int                n_ignored = 0,
  output logic              poll_moved = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Read side
  // ********************
  logic [2:0]  step = 3'h0;
  logic        tog = 1'b0;
  int          left = 0;
  logic [15:0] val;
  logic [15:0] last = 16'h0;
  logic [18:0] poll_at = '0;
  wire rd = !pins.ce_n && !pins.oe_n && pins.reset_n;
  wire wr = !pins.ce_n && !pins.we_n && pins.reset_n;
  always_comb begin
    if (left > 0) val = {9'h0, tog, 6'h15};
    else if (id_mode) val = pins.addr[0] ? DEV_CODE : MFR_CODE;
    else val = {pins.addr[7:0], ~pins.addr[7:0]};
  end
  // Released bus shows the inverse so a stale value never passes
  assign dq = rd ? val : ~last;
  always @(posedge rd) begin
    if (left > 0 && left < busy_reads && pins.addr !== poll_at) poll_moved = 1'b1;
    poll_at = pins.addr;
  end
  always @(negedge rd) begin
    last = val;
    n_reads++;
    tog = (left > 0) ? ~tog : tog;
    left = (left > 0) ? left - 1 : 0;
  end
  // ********************
  // Write side
  // ********************
  always @(negedge wr) begin
    if (left > 0) n_ignored++;
    else take(pins.addr, pins.dq_out[7:0]);
  end
  always @(posedge pwr_off) begin
    id_mode = 1'b0;
    left = 0;
    step = 3'h0;
    erase_kind = 3'h0;
  end
  task automatic take(input logic [18:0] a, input logic [7:0] d);
    logic [2:0] s;
    s = step;
    step = 3'h0;
    if (d == 8'hF0 && s != 3'h5) id_mode = 1'b0;
    case (s)
      3'h0, 3'h3: if (a[15:0] == 16'h5555 && d == 8'hAA) step = s + 3'h1;
      3'h1, 3'h4: if (a[15:0] == 16'h2AAA && d == 8'h55) step = s + 3'h1;
      3'h2: begin
        if (d == 8'h90) id_mode = 1'b1;
        if (d == 8'h80) step = 3'h3;
      end
      default: begin
        if (d == 8'h10 && a[15:0] == 16'h5555) erase_kind = 3'h1;
        if (d == 8'h30) erase_kind = 3'h2;
        erase_addr = a;
        left = (d == 8'h10 || d == 8'h30) ? busy_reads : 0;
      end
    endcase
  endtask
endmodule // flash_dev_model

/* File: bench/flash_cmd_host_tb.sv */
/* Testbench for the flash command host against a behavioural flash.
   Assumes a 40 MHz mclk and a short erase timeout for simulation. */
`include "flash_host_defines.svh"
module flash_cmd_host_tb
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] MFR_C = 16'h00C3; // Arbitrary value
  localparam logic [15:0] DEV_C = 16'h005C; // Arbitrary value
  logic mclk, rst, clk_en, cmd_valid, cmd_ready, rsp_valid, rsp_timeout, pwr_off;
  op_t               cmd_op;
  logic [18:0]       cmd_addr, erase_addr;
  logic [15:0]       rsp_data, dq_in, busy_reads, r_data;
  flash_pins_t       pins;
  logic              id_mode, poll_moved, r_tmo;
  logic [2:0]        erase_kind;
  int                n_reads, n_ignored, n_fail = 0, check_count = 0;
  flash_cmd_host #(.ERASE_TMO(200)) i_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
    .pins(pins), .dq_in(dq_in));
  flash_dev_model #(.MFR_CODE(MFR_C), .DEV_CODE(DEV_C)) i_model (.pins(pins), .dq(dq_in),
    .pwr_off(pwr_off), .busy_reads(busy_reads), .id_mode(id_mode), .erase_kind(erase_kind),
    .erase_addr(erase_addr), .n_reads(n_reads), .n_ignored(n_ignored),
    .poll_moved(poll_moved));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded waits: a hang counts a mismatch and ends the run
  task automatic run_op(input op_t op, input logic [18:0] a);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      #2;
      n++;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_valid = 1'b1;
    @(posedge mclk);
    #2;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 8000) begin
      @(posedge mclk);
      #2;
      n++;
    end
    if (rsp_valid !== 1'b1) begin
      check(1'b0, 1'b1);
      complete_run();
    end
    r_data = rsp_data;
    r_tmo = rsp_timeout;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic erase_case(input op_t op, input logic [18:0] a, input logic [2:0] k,
                            input logic [18:0] at);
    int n0;
    n0 = n_reads;
    busy_reads = 16'h0004;
    run_op(op, a);
    check(erase_kind, k);
    check(erase_addr, at);
    check(r_tmo, 1'b0);
    check(r_data, {a[7:0], ~a[7:0]});
    check(n_reads - n0 >= 5 && n_reads - n0 <= 6, 1'b1);
    check(n_ignored, 0);
    check(poll_moved, 1'b0);
  endtask
  task automatic timeout_case();
    busy_reads = 16'h03E8;
    run_op(OP_CHIP_ERASE, 19'h0_0040);
    check(r_tmo, 1'b1);
    check(n_ignored, 0);
    pulse_power();
  endtask
  task automatic id_case(input op_t ex);
    run_op(OP_ID_ENTER, 19'h0_0000);
    run_op(OP_READ, 19'h0_0000);
    check(r_data, MFR_C);
    run_op(OP_READ, 19'h0_0001);
    check(r_data, DEV_C);
    run_op(ex, 19'h0_0000);
    run_op(OP_READ, 19'h0_0001);
    check(r_data, 16'h01FE);
  endtask
  task automatic pulse_power();
    pwr_off = 1'b1;
    @(posedge mclk);
    #2;
    pwr_off = 1'b0;
  endtask
  task automatic power_case();
    run_op(OP_ID_ENTER, 19'h0_0000);
    check(id_mode, 1'b1);
    pulse_power();
    run_op(OP_READ, 19'h0_0000);
    check(r_data, 16'h00FF);
  endtask
  // Clock enable low freezes the host: an offered operation is not taken
  task automatic freeze_case();
    @(posedge mclk);
    #2;
    cmd_op = OP_READ;
    cmd_addr = 19'h0_0002;
    cmd_valid = 1'b1;
    clk_en = 1'b0;
    repeat (5) @(posedge mclk);
    #2;
    check(cmd_ready, 1'b1);
    check(pins.ce_n, 1'b1);
    cmd_valid = 1'b0;
    clk_en = 1'b1;
    @(posedge mclk);
    #2;
    run_op(OP_READ, 19'h0_0002);
    check(r_data, 16'h02FD);
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    pwr_off = 1'b0;
    busy_reads = 16'h0004;
    repeat (4) @(posedge mclk);
    #2;
    check({pins.reset_n, pins.ce_n, pins.oe_n, pins.we_n}, 4'h7);
    rst = 1'b0;
    erase_case(OP_CHIP_ERASE, 19'h0_0040, 3'h1, 19'h0_5555);
    erase_case(OP_SECT_ERASE, 19'h4_1234, 3'h2, 19'h4_1234);
    timeout_case();
    erase_case(OP_SECT_ERASE, 19'h2_0077, 3'h2, 19'h2_0077);
    id_case(OP_ID_EXIT);
    id_case(OP_ID_EXIT_SHORT);
    power_case();
    freeze_case();
    complete_run();
  end
endmodule // flash_cmd_host_tb
bind flash_cmd_host flash_cmd_host_asserts i_chk (.mclk(mclk), .rst(rst), .clk_en(clk_en),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .pins(pins));
